// ### include/hcc_pkg.sv
// harmonic engine configuration: register map, field layout, timing constants
// assumes a single 50 MHz clock and a plain strobe register port
`default_nettype none
package hcc_pkg;
    // register map (byte addresses on the register port)
    localparam logic [15:0] ADDR_CONFIG = 16'hE900;
    localparam logic [15:0] ADDR_STATUS = 16'hE500;
    localparam logic [15:0] ADDR_MASK   = 16'hE504;

    localparam logic [15:0] CONFIG_RESET = 16'h0008;
    localparam int          READY_BIT    = 19;
    localparam logic [2:0]  RATE_OFF     = 3'h7;
    localparam logic [1:0]  TB_PHASE_C   = 2'h2;
    localparam logic [1:0]  TB_RESERVED  = 2'h3;

    // timing
    localparam int CLK_PERIOD_NS   = 20;
    localparam int TICK_US         = 125;
    localparam int TICK_CYCLES_DEF = (TICK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_MS_0     = 500;
    localparam int SETTLE_MS_1     = 750;
    localparam int SETTLE_MS_2     = 1000;
    localparam int SETTLE_MS_3     = 1250;
    localparam int PERIOD_US_0     = 125;
    localparam int PERIOD_US_1     = 250;
    localparam int PERIOD_US_2     = 1000;
    localparam int PERIOD_US_3     = 16000;
    localparam int PERIOD_US_4     = 128000;
    localparam int PERIOD_US_5     = 512000;
    localparam int PERIOD_US_6     = 1024000;

    typedef struct packed {
        logic [5:0] reserved;
        logic [1:0] timebase;
        logic [2:0] rate;
        logic [1:0] settle;
        logic [1:0] channel;
        logic       ready_now;
    } hcc_cfg_t;

    typedef struct packed {
        logic        we;
        logic        re;
        logic [15:0] addr;
        logic [31:0] wdata;
    } hcc_bus_req_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_SETTLE = 2'h1,
        ST_RUN    = 2'h3,
        ST_OFF    = 2'h2
    } hcc_state_t;

    function automatic logic [13:0] hcc_settle_ticks(input logic [1:0] sel);
        case (sel)
            2'h0:    hcc_settle_ticks = 14'(SETTLE_MS_0 * 1000 / TICK_US);
            2'h1:    hcc_settle_ticks = 14'(SETTLE_MS_1 * 1000 / TICK_US);
            2'h2:    hcc_settle_ticks = 14'(SETTLE_MS_2 * 1000 / TICK_US);
            default: hcc_settle_ticks = 14'(SETTLE_MS_3 * 1000 / TICK_US);
        endcase
    endfunction

    function automatic logic [13:0] hcc_period_ticks(input logic [2:0] sel);
        case (sel)
            3'h0:    hcc_period_ticks = 14'(PERIOD_US_0 / TICK_US);
            3'h1:    hcc_period_ticks = 14'(PERIOD_US_1 / TICK_US);
            3'h2:    hcc_period_ticks = 14'(PERIOD_US_2 / TICK_US);
            3'h3:    hcc_period_ticks = 14'(PERIOD_US_3 / TICK_US);
            3'h4:    hcc_period_ticks = 14'(PERIOD_US_4 / TICK_US);
            3'h5:    hcc_period_ticks = 14'(PERIOD_US_5 / TICK_US);
            default: hcc_period_ticks = 14'(PERIOD_US_6 / TICK_US);
        endcase
    endfunction
endpackage
`default_nettype wire

// ### logic/hcc_top.sv
// harmonic engine configuration register, ready scheduling and interrupt
// assumes synchronous inputs on clk_i and a master that never overlaps strobes
// Functional notes
// - with ready timing select at 0, the ready flag bit 19 is raised only after the settling delay, then at the update rate.
// - with ready timing select at 1, the ready flag is raised at once after setup, then at the update rate.
// - channel select bits 2:1 pick phase A, B, C or the neutral current for codes 00 to 11.
// - settling delay bits 4:3 give 500, 750, 1000 or 1250 ms and reset to 01.
// - update rate bits 7:5 give 125 us, 250 us, 1 ms, 16 ms, 128 ms, 512 ms or 1.024 s for codes 000 to 110.
// - update rate code 111 disables the harmonic calculations so no result refresh happens.
// - time base bits 9:8 choose the phase voltage used as time base, 00 being phase A.
// - time base code 01 is phase B, 10 is phase C and the reserved 11 acts as phase C.
// - bits 15:10 of the configuration are reserved, read zero and affect nothing.
//
// Implementation choice: the address-and-strobe port.
`default_nettype none
module hcc_top #(
    parameter int TICK_CYCLES = hcc_pkg::TICK_CYCLES_DEF
) (
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    input  wire hcc_pkg::hcc_bus_req_t bus_i,
    output logic [31:0]               rdata_o,
    output logic                      irq_o,
    output logic [1:0]                channel_sel_o,
    output logic [1:0]                timebase_sel_o,
    output logic                      calc_enable_o,
    output logic                      result_update_o
);
    import hcc_pkg::*;

    logic [1:0]  rst_sync_q;
    logic        rst_n;
    hcc_cfg_t    cfg_q;
    hcc_state_t  state_q;
    hcc_state_t  state_d;
    logic [15:0] tick_cnt_q;
    logic        tick;
    logic [13:0] ev_cnt_q;
    logic [13:0] ev_cnt_d;
    logic        set_ready;
    logic        ready_q;
    logic        ready_d;
    logic        mask_q;
    logic [31:0] rdata_q;
    logic        irq_q;
    logic [1:0]  chan_q;
    logic [1:0]  tb_q;
    logic        en_q;
    logic        upd_q;
    logic        cfg_wr;
    logic        stat_wr;
    logic        mask_wr;

    // reset release through two flops, first flop feeds only the second
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign cfg_wr  = bus_i.we && (bus_i.addr == ADDR_CONFIG);
    assign stat_wr = bus_i.we && (bus_i.addr == ADDR_STATUS);
    assign mask_wr = bus_i.we && (bus_i.addr == ADDR_MASK);

    // reserved bits are never stored, so they read zero
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= hcc_cfg_t'(CONFIG_RESET);
        end else if (cfg_wr) begin
            cfg_q          <= hcc_cfg_t'(bus_i.wdata[15:0]);
            cfg_q.reserved <= 6'h00;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= 1'b0;
        end else if (mask_wr) begin
            mask_q <= bus_i.wdata[READY_BIT];
        end
    end

    // base tick of 125 us; restarted on a config write and while idle, so the
    // first settling delay or update period after setup is a whole tick count long
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 16'h0000;
        end else if (cfg_wr || tick || state_q == ST_IDLE) begin
            tick_cnt_q <= 16'h0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end
    assign tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));

    always_comb begin
        state_d   = state_q;
        ev_cnt_d  = ev_cnt_q;
        set_ready = 1'b0;
        if (cfg_wr) begin
            state_d  = ST_IDLE;
            ev_cnt_d = 14'h0000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    ev_cnt_d = 14'h0000;
                    if (cfg_q.rate == RATE_OFF) begin
                        state_d = ST_OFF;
                    end else if (cfg_q.ready_now) begin
                        state_d   = ST_RUN;
                        set_ready = 1'b1;
                    end else begin
                        state_d = ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (tick) begin
                        if (ev_cnt_q == hcc_settle_ticks(cfg_q.settle) - 14'h0001) begin
                            state_d   = ST_RUN;
                            set_ready = 1'b1;
                            ev_cnt_d  = 14'h0000;
                        end else begin
                            ev_cnt_d = ev_cnt_q + 14'h0001;
                        end
                    end
                end
                ST_RUN: begin
                    if (tick) begin
                        if (ev_cnt_q == hcc_period_ticks(cfg_q.rate) - 14'h0001) begin
                            set_ready = 1'b1;
                            ev_cnt_d  = 14'h0000;
                        end else begin
                            ev_cnt_d = ev_cnt_q + 14'h0001;
                        end
                    end
                end
                ST_OFF: begin
                    state_d = ST_OFF;
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= ST_IDLE;
            ev_cnt_q <= 14'h0000;
        end else begin
            state_q  <= state_d;
            ev_cnt_q <= ev_cnt_d;
        end
    end

    // sticky ready flag: hardware set beats a software one-to-clear
    always_comb begin
        ready_d = ready_q;
        if (cfg_wr) begin
            ready_d = 1'b0;
        end else if (stat_wr && bus_i.wdata[READY_BIT]) begin
            ready_d = 1'b0;
        end
        if (set_ready) begin
            ready_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ready_q <= 1'b0;
            irq_q   <= 1'b0;
            upd_q   <= 1'b0;
        end else begin
            ready_q <= ready_d;
            irq_q   <= ready_d && (mask_wr ? bus_i.wdata[READY_BIT] : mask_q);
            upd_q   <= set_ready;
        end
    end

    // routing selects for the engine
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            chan_q <= 2'h0;
            tb_q   <= 2'h0;
            en_q   <= 1'b0;
        end else begin
            chan_q <= cfg_q.channel;
            tb_q   <= (cfg_q.timebase == TB_RESERVED) ? TB_PHASE_C : cfg_q.timebase;
            en_q   <= (cfg_q.rate != RATE_OFF);
        end
    end

    // read data only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (bus_i.re) begin
            case (bus_i.addr)
                ADDR_CONFIG: rdata_q <= {16'h0000, 16'(cfg_q)};
                ADDR_STATUS: rdata_q <= 32'(ready_q) << READY_BIT;
                ADDR_MASK:   rdata_q <= 32'(mask_q) << READY_BIT;
                default:     rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign rdata_o         = rdata_q;
    assign irq_o           = irq_q;
    assign channel_sel_o   = chan_q;
    assign timebase_sel_o  = tb_q;
    assign calc_enable_o   = en_q;
    assign result_update_o = upd_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    delayed_ready_a: assert property (
        state_q == ST_SETTLE && !cfg_wr && !(stat_wr && bus_i.wdata[READY_BIT]) |=> !ready_q || state_q == ST_RUN)
        else $error("ready flag rose during settling");

    settle_end_a: assert property (
        state_q == ST_SETTLE && tick && !cfg_wr && ev_cnt_q == hcc_settle_ticks(cfg_q.settle) - 14'h0001
        |=> state_q == ST_RUN && ready_q && result_update_o)
        else $error("settling end did not raise ready");

    immediate_ready_a: assert property (
        cfg_wr && bus_i.wdata[0] && bus_i.wdata[7:5] != RATE_OFF ##1 !cfg_wr |=> ready_q && state_q == ST_RUN)
        else $error("immediate ready missing");

    update_period_a: assert property (
        state_q == ST_RUN && !cfg_wr && !(tick && ev_cnt_q == hcc_period_ticks(cfg_q.rate) - 14'h0001)
        |=> !result_update_o)
        else $error("update outside its period");

    calc_off_a: assert property (
        state_q == ST_OFF |-> !set_ready ##1 !calc_enable_o && !result_update_o)
        else $error("update while calculations disabled");

    channel_route_a: assert property (
        cfg_wr |-> ##2 channel_sel_o == $past(bus_i.wdata[2:1], 2))
        else $error("channel select not routed");

    timebase_route_a: assert property (
        cfg_wr |-> ##2 timebase_sel_o == (($past(bus_i.wdata[9:8], 2) == TB_RESERVED) ? TB_PHASE_C
                                          : $past(bus_i.wdata[9:8], 2)))
        else $error("time base select wrong");

    reserved_zero_a: assert property (
        bus_i.re && bus_i.addr == ADDR_CONFIG |=> rdata_o[31:10] == 22'h000000)
        else $error("reserved config bits not zero");

    restart_clear_a: assert property (
        cfg_wr |=> state_q == ST_IDLE && !ready_q && ev_cnt_q == 14'h0000)
        else $error("config write did not restart");

    irq_gate_a: assert property (
        irq_o == (ready_q && mask_q))
        else $error("interrupt not gated by mask");

    flag_clear_a: assert property (
        stat_wr && bus_i.wdata[READY_BIT] && !set_ready |=> !ready_q)
        else $error("ready flag not cleared by one");

    set_wins_a: assert property (
        set_ready |=> ready_q && result_update_o)
        else $error("ready set lost against a clear");

    update_flag_a: assert property (
        result_update_o |-> ready_q)
        else $error("update pulse without ready flag");

    period_count_a: assert property (
        state_q == ST_RUN |-> ev_cnt_q < hcc_period_ticks(cfg_q.rate))
        else $error("period counter past its end");

    settle_count_a: assert property (
        state_q == ST_SETTLE |-> ev_cnt_q < hcc_settle_ticks(cfg_q.settle))
        else $error("settling counter past its end");

    off_hold_a: assert property (
        state_q == ST_OFF && !cfg_wr |=> state_q == ST_OFF && !ready_q)
        else $error("disabled engine left its off state");

    enable_level_a: assert property (
        !cfg_wr ##1 !cfg_wr |=> calc_enable_o == (cfg_q.rate != RATE_OFF))
        else $error("calculation enable wrong");

    timebase_code_a: assert property (
        timebase_sel_o != TB_RESERVED)
        else $error("reserved time base code routed");

    settle_run_c:    cover property (state_q == ST_SETTLE ##1 state_q == ST_RUN);
    immediate_run_c: cover property (state_q == ST_IDLE ##1 state_q == ST_RUN);
    disabled_c:      cover property (state_q == ST_OFF);
    periodic_upd_c:  cover property (state_q == ST_RUN && result_update_o);
    irq_raised_c:    cover property ($rose(irq_o));
endmodule
`default_nettype wire

// ### verif/tb_hcc_top.sv
// self-checking bench for the harmonic engine configuration block
// assumes hcc_pkg is compiled first; the bench drives the strobe register port itself
`default_nettype none
module tb_hcc_top;
    timeunit 1ns;
    timeprecision 1ps;
    import hcc_pkg::*;

    // short tick keeps the settling waits inside the run budget
    localparam int TICK = 4;
    localparam logic [31:0] READY_MASK = 32'h0008_0000;

    logic         clk_i;
    logic         resetn_i;
    hcc_bus_req_t bus_i;
    logic [31:0]  rdata_o;
    logic         irq_o;
    logic [1:0]   channel_sel_o;
    logic [1:0]   timebase_sel_o;
    logic         calc_enable_o;
    logic         result_update_o;
    int           err_total = 0;
    int           num_checks = 0;
    int           n;
    int           per[6] = '{1, 2, 8, 128, 1024, 4096};

    hcc_top #(.TICK_CYCLES(TICK)) u_hcc_top (
        .clk_i          (clk_i),
        .resetn_i       (resetn_i),
        .bus_i          (bus_i),
        .rdata_o        (rdata_o),
        .irq_o          (irq_o),
        .channel_sel_o  (channel_sel_o),
        .timebase_sel_o (timebase_sel_o),
        .calc_enable_o  (calc_enable_o),
        .result_update_o(result_update_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    function automatic logic [31:0] cfg(input logic rn, input logic [1:0] ch, input logic [1:0] st,
                                        input logic [2:0] rt, input logic [1:0] tb);
        cfg = {22'h0, tb, rt, st, ch, rn};
    endfunction

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t value got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("ERROR t=%0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus_i.we    <= 1'b1;
        bus_i.addr  <= a;
        bus_i.wdata <= d;
        @(posedge clk_i);
        bus_i <= '0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] got;
        @(posedge clk_i);
        bus_i.re   <= 1'b1;
        bus_i.addr <= a;
        @(posedge clk_i);
        bus_i <= '0;
        #1;
        got = rdata_o;
        chk_val(got, exp);
    endtask

    task automatic settle_out();
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    // counts cycles up to the next update pulse; a lost pulse ends the run
    task automatic wait_pulse(input int max, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk_i);
            #1;
            cnt++;
        end while (result_update_o !== 1'b1 && cnt < max);
        if (result_update_o !== 1'b1) begin
            err_total++;
            $display("ERROR t=%0t no update pulse", $time);
            conclude();
        end
    endtask

    task automatic quiet(input int ncyc);
        int hits;
        hits = 0;
        repeat (ncyc) begin
            @(posedge clk_i);
            #1;
            if (result_update_o !== 1'b0) hits++;
        end
        chk_cnt(hits, 0, 0);
    endtask

    initial begin
        resetn_i = 1'b0;
        bus_i    = '0;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd_chk(ADDR_CONFIG, 32'h0000_0008);
        rd_chk(ADDR_STATUS, 32'h0);
        rd_chk(16'hE702, 32'h0);
        // every field at its top code, reserved bits set
        wr(ADDR_CONFIG, 32'hFFFF_FFFF);
        rd_chk(ADDR_CONFIG, 32'h0000_03FF);
        settle_out();
        chk_val(32'(calc_enable_o), 32'h0);
        chk_val(32'(timebase_sel_o), 32'h2);
        quiet(60);
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_CONFIG, cfg(1'b1, 2'(k), 2'(k), 3'h0, 2'(k)));
            settle_out();
            chk_val(32'(channel_sel_o), 32'(k));
            chk_val(32'(timebase_sel_o), (k == 3) ? 32'h2 : 32'(k));
            chk_val(32'(calc_enable_o), 32'h1);
        end
        // immediate ready, then one pulse per update period
        for (int r = 0; r < 6; r++) begin
            wr(ADDR_CONFIG, cfg(1'b1, 2'h0, 2'h0, 3'(r), 2'h0));
            wait_pulse(4, n);
            chk_cnt(n, 1, 2);
            wait_pulse(per[r] * TICK + 4, n);
            chk_cnt(n, per[r] * TICK, per[r] * TICK);
        end
        // interrupt raise, clear, mask
        wr(ADDR_MASK, READY_MASK);
        rd_chk(ADDR_MASK, READY_MASK);
        wr(ADDR_CONFIG, cfg(1'b1, 2'h0, 2'h0, 3'h6, 2'h0));
        wait_pulse(4, n);
        settle_out();
        chk_val(32'(irq_o), 32'h1);
        rd_chk(ADDR_STATUS, READY_MASK);
        wr(ADDR_STATUS, READY_MASK);
        settle_out();
        chk_val(32'(irq_o), 32'h0);
        rd_chk(ADDR_STATUS, 32'h0);
        wr(ADDR_MASK, 32'h0);
        wr(ADDR_CONFIG, cfg(1'b1, 2'h0, 2'h0, 3'h6, 2'h0));
        settle_out();
        chk_val(32'(irq_o), 32'h0);
        // a config write drops the pending flag and restarts settling
        wr(ADDR_CONFIG, cfg(1'b0, 2'h0, 2'h0, 3'h6, 2'h0));
        rd_chk(ADDR_STATUS, 32'h0);
        wr(ADDR_MASK, READY_MASK);
        quiet(8000);
        wr(ADDR_CONFIG, cfg(1'b0, 2'h0, 2'h0, 3'h6, 2'h0));
        wait_pulse(4000 * TICK + 8, n);
        chk_cnt(n, 4000 * TICK, 4000 * TICK + 3);
        settle_out();
        chk_val(32'(irq_o), 32'h1);
        rd_chk(ADDR_STATUS, READY_MASK);
        // second settling code, measured from the write that restarts it
        wr(ADDR_CONFIG, cfg(1'b0, 2'h0, 2'h1, 3'h6, 2'h0));
        settle_out();
        chk_val(32'(irq_o), 32'h0);
        wait_pulse(6000 * TICK + 8, n);
        chk_cnt(n, 6000 * TICK - 2, 6000 * TICK + 1);
        conclude();
    end
endmodule
`default_nettype wire
